/* File: rtl/sep_device.sv */
// Decided for this implementation: the APB slave port and the placing of the registers.
`default_nettype none
`include "sep_defines.svh"
module sep_device #(
   parameter int AW = `SEP_ADDR_BITS,
   parameter int PROG_CYCLES = `SEP_PROG_CYCLES
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clk_en,
   sep_link_if.device link,
   output logic prog_busy,
   output logic prog_unlocked,
   output logic guard_frozen
);
   import sep_pkg::*;
   localparam int TW = $clog2(PROG_CYCLES + 1);
   localparam int WB = `SEP_WORD_BITS;
   sep_dev_state_type state_q;
   logic [4:0] pin_lvl, pin_rise, pin_fall;
   logic cs, sk_rise, cs_fall, si, pe, gs, decode, go_read, go_data, start, commit;
   logic [3:0] cnt_q, ocnt_q;
   logic [WB-1:0] in_q, sh_q;
   logic [9:0] code;
   logic [1:0] op;
   logic [7:0] ad, addr_q, rd_addr_q, gaddr_q;
   logic fill_q, pend_q, gread_q, unlock_q, armed_q, gvalid_q, frozen_q, busy_q, status_q, do_q, oe_q;
   logic [TW-1:0] timer_q;
   logic [WB-1:0] mem_q [2**AW];
   function automatic logic may_program(input logic fill, input logic [7:0] a, input logic unl,
                                        input logic gv, input logic [7:0] ga);
      may_program = unl & (fill ? !gv : !(gv && a >= ga));
   endfunction
   sep_sync_edge #(.W(5)) u_sync (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
      .d({link.cs, link.shift_clock, link.serial_input, link.program_enable, link.guard_select}),
      .level(pin_lvl), .rise(pin_rise), .fall(pin_fall));
   assign cs = pin_lvl[4];
   assign cs_fall = pin_fall[4];
   assign sk_rise = pin_rise[3] & cs;
   assign si = pin_lvl[2];
   assign pe = pin_lvl[1];
   assign gs = pin_lvl[0];
   assign code = {in_q[8:0], si};
   assign op = code[9:8];
   assign ad = code[7:0];
   assign decode = (state_q == DEV_CMD) && sk_rise && (cnt_q == 4'(`SEP_CMD_BITS - 1));
   assign go_read = decode && (op == `SEP_OP_READ);
   assign go_data = decode && !gs && pe && ((op == `SEP_OP_WRITE) ||
                    (op == `SEP_OP_MISC && ad[7:6] == `SEP_SUB_FILL));
   assign start = pend_q && cs_fall && may_program(fill_q, addr_q, unlock_q, gvalid_q, gaddr_q);
   assign commit = busy_q && (timer_q == TW'(PROG_CYCLES - 1));
   // Framing of bits into instruction and data
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         state_q <= DEV_IDLE;
         cnt_q <= 4'h0;
         in_q <= 16'h0000;
      end
      else if (clk_en)
      begin
         if (!cs)
         begin
            state_q <= DEV_IDLE;
            cnt_q <= 4'h0;
         end
         else
         begin
            unique case (state_q)
               DEV_IDLE:
               begin
                  if (sk_rise && si && !busy_q)
                  begin
                     state_q <= DEV_CMD;
                     cnt_q <= 4'h0;
                  end
               end
               DEV_CMD, DEV_DATA:
               begin
                  if (sk_rise)
                  begin
                     in_q <= {in_q[WB-2:0], si};
                     cnt_q <= cnt_q + 4'h1;
                     if (decode)
                     begin
                        cnt_q <= 4'h0;
                        state_q <= go_read ? DEV_READ : (go_data ? DEV_DATA : DEV_HOLD);
                     end
                     else if (state_q == DEV_DATA && cnt_q == 4'(WB - 1))
                        state_q <= DEV_HOLD;
                  end
               end
               DEV_READ, DEV_HOLD: state_q <= state_q;
            endcase
         end
      end
   end
   // Instruction effects on lock and guard state
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         unlock_q <= 1'b0;
         armed_q <= 1'b0;
         gvalid_q <= 1'b0;
         gaddr_q <= `SEP_GUARD_RESET;
         frozen_q <= 1'b0;
         addr_q <= 8'h00;
         fill_q <= 1'b0;
      end
      else if (clk_en && decode)
      begin
         armed_q <= 1'b0;
         addr_q <= ad;
         fill_q <= (op == `SEP_OP_MISC);
         if (!gs && op == `SEP_OP_MISC)
         begin
            if (ad[7:6] == `SEP_SUB_UNLOCK && pe)
               unlock_q <= 1'b1;
            else if (ad[7:6] == `SEP_SUB_LOCK)
               unlock_q <= 1'b0;
         end
         else if (gs && pe)
         begin
            if (op == `SEP_OP_MISC && ad[7:6] == `SEP_SUB_UNLOCK)
               armed_q <= unlock_q;
            else if (armed_q && !frozen_q)
            begin
               if (op == `SEP_OP_GCLEAR && ad == `SEP_GCLEAR_ADDR)
                  gvalid_q <= 1'b0;
               else if (op == `SEP_OP_WRITE && !gvalid_q)
               begin
                  gvalid_q <= 1'b1;
                  gaddr_q <= ad;
               end
               else if (op == `SEP_OP_MISC && ad == `SEP_GFREEZE_ADDR)
                  frozen_q <= 1'b1;
            end
         end
      end
   end
   // Pending write waits for select to fall; an extra clock rise discards it
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
         pend_q <= 1'b0;
      else if (clk_en)
      begin
         if (state_q == DEV_DATA && sk_rise && cnt_q == 4'(WB - 1))
            pend_q <= 1'b1;
         else if (cs_fall || (state_q == DEV_HOLD && sk_rise))
            pend_q <= 1'b0;
      end
   end
   // Self-timed programming cycle and status reporting
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         busy_q <= 1'b0;
         timer_q <= '0;
         status_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (start)
         begin
            busy_q <= 1'b1;
            timer_q <= '0;
            status_q <= 1'b1;
         end
         else
         begin
            if (busy_q)
               timer_q <= timer_q + TW'(1);
            if (commit)
               busy_q <= 1'b0;
            // Ready stays visible until select falls or the host clocks in the start bit of a new instruction
            if (!busy_q && (cs_fall || (state_q == DEV_IDLE && sk_rise && si)))
               status_q <= 1'b0;
         end
      end
   end
   generate
      for (genvar i = 0; i < 2**AW; i++)
      begin : g_word
         always_ff @(posedge mclk)
         begin
            if (!reset_n)
               mem_q[i] <= `SEP_MEM_RESET;
            else if (clk_en && commit && (fill_q || addr_q[AW-1:0] == AW'(i)))
               mem_q[i] <= in_q;
         end
      end
   endgenerate
   // Serial output shifter; read path never looks at the lock state
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         do_q <= 1'b0;
         oe_q <= 1'b0;
         sh_q <= 16'h0000;
         ocnt_q <= 4'h0;
         rd_addr_q <= 8'h00;
         gread_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (!cs)
            oe_q <= 1'b0;
         else if (go_read)
         begin
            oe_q <= 1'b1;
            do_q <= 1'b0;
            sh_q <= gs ? {gaddr_q, 8'h00} : mem_q[ad[AW-1:0]];
            gread_q <= gs;
            rd_addr_q <= ad + 8'h01;
            ocnt_q <= 4'h0;
         end
         else if (state_q == DEV_READ && sk_rise)
         begin
            do_q <= sh_q[WB-1];
            sh_q <= {sh_q[WB-2:0], 1'b0};
            ocnt_q <= ocnt_q + 4'h1;
            if (ocnt_q == 4'(WB - 1) && !gread_q)
            begin
               sh_q <= mem_q[rd_addr_q[AW-1:0]];
               rd_addr_q <= rd_addr_q + 8'h01;
            end
         end
         else if (state_q == DEV_IDLE && sk_rise && si && !busy_q)
            oe_q <= 1'b0;
         else if (status_q && state_q == DEV_IDLE)
         begin
            oe_q <= 1'b1;
            do_q <= !busy_q;
         end
      end
   end

   assign link.serial_output = do_q;
   assign link.serial_output_oe = oe_q;
   assign prog_busy = busy_q;
   assign prog_unlocked = unlock_q;
   assign guard_frozen = frozen_q;
endmodule
`default_nettype wire

/* File: rtl/sep_host.sv */
`default_nettype none
`include "sep_defines.svh"
module sep_host (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire sep_pkg::sep_word_type pwdata,
   output sep_pkg::sep_word_type prdata,
   output logic pready,
   output logic pslverr,
   sep_link_if.host link
);
   import sep_pkg::*;

   localparam int HALF = `SEP_SK_HALF_CYCLES;
   localparam int GAP = `SEP_CS_LOW_CYCLES;
   localparam int SV = `SEP_SV_CYCLES;

   sep_host_state_type state_q;
   logic [1:0] so_lvl;
   logic [26:0] tx_q;
   logic [6:0] total_q;
   logic [6:0] done_q;
   logic [6:0] rx_from_q;
   logic [5:0] div_q;
   sep_word_type rx_q;
   logic [15:0] wdata_q;
   logic poll_q, busy_q, ready_q;
   logic cs_q, sk_q, si_q, pe_q, gs_q;
   sep_word_type prdata_q;
   logic pready_q, pslverr_q;
   logic wr_cmd;

   function automatic logic [2:0] reg_sel(input logic [7:0] a);
      unique case (a)
         `SEP_REG_CMD: reg_sel = 3'h1;
         `SEP_REG_WDATA: reg_sel = 3'h2;
         `SEP_REG_STATUS: reg_sel = 3'h3;
         `SEP_REG_RDATA: reg_sel = 3'h4;
         default: reg_sel = 3'h0;
      endcase
   endfunction

   sep_sync_edge #(.W(2)) u_sync (
      .mclk(mclk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .d({link.serial_output, link.serial_output_oe}),
      .level(so_lvl),
      .rise(),
      .fall()
   );

   // Commands are refused while a transfer is running
   assign wr_cmd = psel && penable && pready_q && pwrite && reg_sel(paddr) == 3'h1 && !busy_q;

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         wdata_q <= 16'h0000;
      end
      else if (clk_en)
      begin
         pready_q <= psel && !penable;
         if (psel && !penable)
         begin
            pslverr_q <= reg_sel(paddr) == 3'h0;
            unique case (reg_sel(paddr))
               3'h2: prdata_q <= {16'h0000, wdata_q};
               3'h3: prdata_q <= {30'h0000_0000, ready_q, busy_q};
               3'h4: prdata_q <= rx_q;
               default: prdata_q <= 32'h0000_0000;
            endcase
         end
         if (psel && penable && pready_q && pwrite && reg_sel(paddr) == 3'h2)
            wdata_q <= pwdata[15:0];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         state_q <= HST_IDLE;
         busy_q <= 1'b0;
         ready_q <= 1'b0;
         poll_q <= 1'b0;
         cs_q <= 1'b0;
         sk_q <= 1'b0;
         si_q <= 1'b0;
         pe_q <= 1'b0;
         gs_q <= 1'b0;
         tx_q <= '0;
         total_q <= 7'h00;
         done_q <= 7'h00;
         rx_from_q <= 7'h00;
         div_q <= 6'h00;
         rx_q <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         div_q <= div_q + 6'h01;
         unique case (state_q)
            HST_IDLE:
            begin
               if (wr_cmd)
               begin
                  tx_q <= {1'b1, pwdata[`SEP_CMD_OP_LSB +: 2], pwdata[`SEP_CMD_ADDR_LSB +: 8], wdata_q};
                  rx_from_q <= pwdata[`SEP_CMD_DATA_BIT] ? 7'h1b : 7'h0b;
                  total_q <= (pwdata[`SEP_CMD_DATA_BIT] ? 7'h1b : 7'h0b) + {1'b0, pwdata[`SEP_CMD_RLEN_LSB +: 6]};
                  pe_q <= pwdata[`SEP_CMD_PE_BIT];
                  gs_q <= pwdata[`SEP_CMD_GUARD_BIT];
                  poll_q <= pwdata[`SEP_CMD_POLL_BIT];
                  done_q <= 7'h00;
                  div_q <= 6'h00;
                  busy_q <= 1'b1;
                  ready_q <= 1'b0;
                  state_q <= HST_GAP;
               end
            end
            HST_GAP:
            begin
               if (div_q == 6'(GAP - 1))
               begin
                  cs_q <= 1'b1;
                  si_q <= tx_q[26];
                  tx_q <= {tx_q[25:0], 1'b0};
                  div_q <= 6'h00;
                  state_q <= HST_LOW;
               end
            end
            HST_LOW:
            begin
               if (div_q == 6'(HALF - 1))
               begin
                  sk_q <= 1'b1;
                  if (done_q >= rx_from_q)
                     rx_q <= {rx_q[30:0], so_lvl[1]};
                  div_q <= 6'h00;
                  state_q <= HST_HIGH;
               end
            end
            HST_HIGH:
            begin
               if (div_q == 6'(HALF - 1))
               begin
                  sk_q <= 1'b0;
                  div_q <= 6'h00;
                  done_q <= done_q + 7'h01;
                  if (done_q + 7'h01 == total_q)
                  begin
                     cs_q <= 1'b0;
                     pe_q <= 1'b0;
                     gs_q <= 1'b0;
                     busy_q <= poll_q;
                     state_q <= poll_q ? HST_PWAIT : HST_IDLE;
                  end
                  else
                  begin
                     si_q <= tx_q[26];
                     tx_q <= {tx_q[25:0], 1'b0};
                     state_q <= HST_LOW;
                  end
               end
            end
            HST_PWAIT:
            begin
               if (div_q == 6'(GAP - 1))
               begin
                  cs_q <= 1'b1;
                  div_q <= 6'h00;
                  state_q <= HST_POLL;
               end
            end
            HST_POLL:
            begin
               // Status is trusted only after the select-to-status delay has passed
               if (div_q >= 6'(SV) && so_lvl[1] && so_lvl[0])
               begin
                  ready_q <= 1'b1;
                  busy_q <= 1'b0;
                  cs_q <= 1'b0;
                  state_q <= HST_IDLE;
               end
            end
         endcase
      end
   end

   assign link.cs = cs_q;
   assign link.shift_clock = sk_q;
   assign link.serial_input = si_q;
   assign link.program_enable = pe_q;
   assign link.guard_select = gs_q;
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
endmodule
`default_nettype wire

/* File: rtl/sep_sync_edge.sv */
`default_nettype none
module sep_sync_edge #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic [W-1:0] d,
   output logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   logic [W-1:0] prev_q;

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end
      else if (clk_en)
      begin
         meta_q <= d;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign level = sync_q;
   assign rise = sync_q & ~prev_q;
   assign fall = ~sync_q & prev_q;
endmodule
`default_nettype wire

/* File: shared/sep_defines.svh */
`ifndef SEP_DEFINES_SVH
`define SEP_DEFINES_SVH

// Timing, in ns, and derived mclk counts
`define SEP_MCLK_NS 25
`define SEP_T_PROG_NS 10000000
`define SEP_T_CS_LOW_NS 250
`define SEP_T_SK_HALF_NS 500
`define SEP_T_SV_NS 500
`define SEP_PROG_CYCLES (`SEP_T_PROG_NS / `SEP_MCLK_NS)
`define SEP_CS_LOW_CYCLES ((`SEP_T_CS_LOW_NS + `SEP_MCLK_NS - 1) / `SEP_MCLK_NS)
`define SEP_SK_HALF_CYCLES ((`SEP_T_SK_HALF_NS + `SEP_MCLK_NS - 1) / `SEP_MCLK_NS)
`define SEP_SV_CYCLES ((`SEP_T_SV_NS + `SEP_MCLK_NS - 1) / `SEP_MCLK_NS)

// Instruction framing
`define SEP_CMD_BITS 10
`define SEP_WORD_BITS 16
`define SEP_ADDR_BITS 8
`define SEP_OP_READ 2'h2
`define SEP_OP_WRITE 2'h1
`define SEP_OP_MISC 2'h0
`define SEP_OP_GCLEAR 2'h3
`define SEP_SUB_UNLOCK 2'h3
`define SEP_SUB_FILL 2'h1
`define SEP_SUB_LOCK 2'h0
`define SEP_GCLEAR_ADDR 8'hff
`define SEP_GFREEZE_ADDR 8'h00

// Reset values
`define SEP_MEM_RESET 16'hffff
`define SEP_GUARD_RESET 8'h00

// Host register map and CMD fields
`define SEP_REG_CMD 8'h00
`define SEP_REG_WDATA 8'h04
`define SEP_REG_STATUS 8'h08
`define SEP_REG_RDATA 8'h0c
`define SEP_CMD_ADDR_LSB 0
`define SEP_CMD_OP_LSB 8
`define SEP_CMD_GUARD_BIT 10
`define SEP_CMD_PE_BIT 11
`define SEP_CMD_DATA_BIT 12
`define SEP_CMD_POLL_BIT 13
`define SEP_CMD_RLEN_LSB 16

`endif

/* File: shared/sep_link_if.sv */
`default_nettype none
interface sep_link_if;
   logic cs;
   logic shift_clock;
   logic serial_input;
   logic program_enable;
   logic guard_select;
   logic serial_output;
   logic serial_output_oe;

   modport device (
      input cs,
      input shift_clock,
      input serial_input,
      input program_enable,
      input guard_select,
      output serial_output,
      output serial_output_oe
   );

   modport host (
      output cs,
      output shift_clock,
      output serial_input,
      output program_enable,
      output guard_select,
      input serial_output,
      input serial_output_oe
   );
endinterface
`default_nettype wire

/* File: shared/sep_pkg.sv */
`default_nettype none
package sep_pkg;
   typedef enum logic [4:0] {
      DEV_IDLE = 5'h01,
      DEV_CMD = 5'h02,
      DEV_DATA = 5'h04,
      DEV_READ = 5'h08,
      DEV_HOLD = 5'h10
   } sep_dev_state_type;

   typedef enum logic [5:0] {
      HST_IDLE = 6'h01,
      HST_GAP = 6'h02,
      HST_LOW = 6'h04,
      HST_HIGH = 6'h08,
      HST_PWAIT = 6'h10,
      HST_POLL = 6'h20
   } sep_host_state_type;

   typedef logic [31:0] sep_word_type;
endpackage
`default_nettype wire

/* File: verification/sep_link_asserts.sv */
`default_nettype none
module sep_link_asserts #(
   parameter int PROG_CYCLES = 50
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic cs,
   input wire logic shift_clock,
   input wire logic serial_input,
   input wire logic program_enable,
   input wire logic guard_select,
   input wire logic serial_output,
   input wire logic serial_output_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic sk_q, cs_q, si_q;
   logic [4:0] cnt_q;
   logic [1:0] op_q;
   logic [7:0] quiet_q;
   logic [19:0] busy_q;
   wire logic sk_rise = shift_clock & ~sk_q;

   always_ff @(posedge mclk)
   begin
      sk_q <= shift_clock;
      cs_q <= cs;
   end

   // Rises seen in the current frame, held at 31 once reached; stays 0 while status is shown
   always_ff @(posedge mclk)
   begin
      if (!reset_n || !cs)
         cnt_q <= 5'h00;
      else if (sk_rise && cnt_q != 5'h1f)
         cnt_q <= cnt_q + 5'h01;
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         si_q <= 1'b0;
         op_q <= 2'h0;
      end
      else if (sk_rise && cs)
      begin
         si_q <= serial_input;
         if (cnt_q == 5'h02)
            op_q <= {si_q, serial_input};
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n || shift_clock != sk_q || cs != cs_q)
         quiet_q <= 8'h00;
      else if (quiet_q != 8'hff)
         quiet_q <= quiet_q + 8'h01;
   end

   always_ff @(posedge mclk)
   begin
      if (reset_n && cs && cnt_q == 5'h00 && serial_output_oe && !serial_output)
         busy_q <= busy_q + 20'h0_0001;
      else
         busy_q <= 20'h0_0000;
   end

   chk_dummy_zero: assert property (@(posedge mclk) disable iff (!reset_n)
      sk_rise && cs && cnt_q == 5'h0a && op_q == 2'h2 |-> ##6 (serial_output_oe && !serial_output))
      else $error("read did not start with a zero bit");
   chk_out_stable: assert property (@(posedge mclk) disable iff (!reset_n)
      quiet_q > 8'h08 && cs && cnt_q != 5'h00 |-> $stable(serial_output))
      else $error("serial output moved without a shift clock rise");
   chk_status_rises: assert property (@(posedge mclk) disable iff (!reset_n)
      cs && $past(cs) && cnt_q == 5'h00 && serial_output_oe && $past(serial_output_oe) |-> !$fell(serial_output))
      else $error("status went from ready back to busy");
   chk_prog_bound: assert property (@(posedge mclk) disable iff (!reset_n)
      busy_q <= 20'(PROG_CYCLES))
      else $error("programming cycle ran too long");
   chk_float_fall: assert property (@(posedge mclk) disable iff (!reset_n)
      $fell(cs) |-> ##[1:6] !serial_output_oe)
      else $error("output still driven after select fell");
   chk_float_idle: assert property (@(posedge mclk) disable iff (!reset_n)
      (!cs) [*8] |-> !serial_output_oe)
      else $error("output driven while deselected");
   chk_reset_float: assert property (@(posedge mclk)
      !reset_n |=> !serial_output_oe)
      else $error("output driven after reset");
   chk_write_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
      cs && op_q == 2'h1 && cnt_q > 5'h0c |-> !serial_output_oe)
      else $error("output driven during write data");
endmodule
`default_nettype wire

/* File: verification/tb.sv */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import sep_pkg::*;
   logic mclk, reset_n, clk_en, psel, penable, pwrite, pready, pslverr, err_q, dev_unl, dev_frz;
   logic [7:0] paddr;
   sep_word_type pwdata, prdata, rv;
   int err_count = 0;
   int samples_checked = 0;
   int cycles = 0;

   sep_link_if link();
   sep_device #(.PROG_CYCLES(50)) i_sep_device (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .link(link),
      .prog_busy(), .prog_unlocked(dev_unl), .guard_frozen(dev_frz));
   sep_host i_sep_host (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link(link));
   sep_link_asserts #(.PROG_CYCLES(50)) i_sep_link_asserts (.mclk(mclk), .reset_n(reset_n), .cs(link.cs),
      .shift_clock(link.shift_clock), .serial_input(link.serial_input), .program_enable(link.program_enable),
      .guard_select(link.guard_select), .serial_output(link.serial_output),
      .serial_output_oe(link.serial_output_oe));

   task automatic stop_test;
      if (err_count == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input sep_word_type got, input sep_word_type exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Entered just after a rising edge; leaves one edge after release
   task automatic apb(input logic w, input logic [7:0] a, input sep_word_type d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do
         @(posedge mclk);
      while (pready !== 1'b1);
      rv = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   function automatic sep_word_type cmd(input logic [7:0] a, input logic [1:0] op, input logic g, input logic pe,
      input logic dat, input logic poll, input logic [5:0] rl);
      return {10'h000, rl, 2'h0, poll, dat, pe, g, op, a};
   endfunction

   // Issue an order and wait for the link to go idle
   task automatic run(input sep_word_type c);
      apb(1'b1, 8'h00, c);
      apb(1'b0, 8'h08, 32'h0000_0000);
      while (rv[0] !== 1'b0)
         apb(1'b0, 8'h08, 32'h0000_0000);
   endtask

   task automatic rd(input logic [7:0] a, input logic g, input logic [5:0] rl);
      run(cmd(a, 2'h2, g, 1'b0, 1'b0, 1'b0, rl));
      apb(1'b0, 8'h0c, 32'h0000_0000);
   endtask

   task automatic wr(input logic [7:0] a, input logic [1:0] op, input logic poll, input logic [15:0] d);
      apb(1'b1, 8'h04, {16'h0000, d});
      run(cmd(a, op, 1'b0, 1'b1, 1'b1, poll, 6'h00));
      if (!poll)
         repeat (200) @(posedge mclk);
   endtask

   task automatic op0(input logic [7:0] a, input logic g);
      run(cmd(a, 2'h0, g, 1'b1, 1'b0, 1'b0, 6'h00));
   endtask

   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 90000)
      begin
         err_count++;
         stop_test;
      end
   end

   initial
   begin
      reset_n = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (4) @(posedge mclk);
      check({31'h0000_0000, dev_unl}, 32'h0000_0000);
      apb(1'b0, 8'h10, 32'h0000_0000);
      check({31'h0000_0000, err_q}, 32'h0000_0001);
      apb(1'b1, 8'h04, 32'h0000_beef);
      apb(1'b0, 8'h04, 32'h0000_0000);
      check(rv & 32'h0000_ffff, 32'h0000_beef);
      rd(8'h05, 1'b0, 6'h11);
      check(rv & 32'h0001_ffff, 32'h0000_ffff);
      wr(8'h05, 2'h1, 1'b0, 16'h1234);
      rd(8'h05, 1'b0, 6'h11);
      check(rv & 32'h0000_ffff, 32'h0000_ffff);
      op0(8'hc0, 1'b0);
      wr(8'h05, 2'h1, 1'b1, 16'ha5c3);
      apb(1'b0, 8'h08, 32'h0000_0000);
      check(rv & 32'h0000_0002, 32'h0000_0002);
      wr(8'h06, 2'h1, 1'b1, 16'h3c5a);
      rd(8'h05, 1'b0, 6'h21);
      check(rv, 32'ha5c3_3c5a);
      op0(8'h00, 1'b0);
      wr(8'h05, 2'h1, 1'b0, 16'h0000);
      rd(8'h05, 1'b0, 6'h11);
      check(rv & 32'h0000_ffff, 32'h0000_a5c3);
      op0(8'hc0, 1'b0);
      op0(8'hc0, 1'b1);
      run(cmd(8'h10, 2'h1, 1'b1, 1'b1, 1'b0, 1'b0, 6'h00));
      rd(8'h00, 1'b1, 6'h09);
      check(rv & 32'h0000_01ff, 32'h0000_0010);
      wr(8'h10, 2'h1, 1'b0, 16'h1111);
      rd(8'h10, 1'b0, 6'h11);
      check(rv & 32'h0000_ffff, 32'h0000_ffff);
      wr(8'h0f, 2'h1, 1'b1, 16'h2222);
      rd(8'h0f, 1'b0, 6'h11);
      check(rv & 32'h0000_ffff, 32'h0000_2222);
      wr(8'h40, 2'h0, 1'b0, 16'h5a5a);
      rd(8'h07, 1'b0, 6'h11);
      check(rv & 32'h0000_ffff, 32'h0000_ffff);
      op0(8'hc0, 1'b1);
      run(cmd(8'hff, 2'h3, 1'b1, 1'b1, 1'b0, 1'b0, 6'h00));
      run(cmd(8'h20, 2'h1, 1'b1, 1'b1, 1'b0, 1'b0, 6'h00));
      wr(8'h30, 2'h1, 1'b0, 16'h7777);
      rd(8'h30, 1'b0, 6'h11);
      check(rv & 32'h0000_ffff, 32'h0000_7777);
      wr(8'h40, 2'h0, 1'b1, 16'h5a5a);
      rd(8'hff, 1'b0, 6'h21);
      check(rv, 32'h5a5a_5a5a);
      check({31'h0000_0000, dev_unl}, 32'h0000_0001);
      op0(8'hc0, 1'b1);
      op0(8'h00, 1'b1);
      check({31'h0000_0000, dev_frz}, 32'h0000_0001);
      stop_test;
   end
endmodule
`default_nettype wire
